/* File: src/csv_pkg.sv */
// Purpose: shared constants and carriers for the coarse seek controller
// Assumes: 20 MHz mclk, one clock domain
// Notes:   all time counts in mclk cycles except UPD_NS, which is in ns
package csv_pkg;
   localparam int TRK_W          = 8;   // tracks-to-go width, max 255
   localparam int TIM_W          = 16;  // crossing-interval timer width
   localparam int DAC_W          = 12;  // desired-current register width
   localparam int CLK_MHZ        = 20;
   localparam int UPD_NS         = 1000; // desired-current update period
   localparam int UPD_CYC        = (UPD_NS * CLK_MHZ) / 1000;
   localparam int SWITCH_TRK     = 12;  // high/low speed switch-over
   localparam int SLEW_MAX       = 64;  // largest step per update
   localparam int GAIN_SHIFT     = 2;   // error to current scaling
   localparam int TIMEOUT_CYC    = 1000000; // seek fault timeout
   localparam logic [TRK_W-1:0] TRK_RST = 8'h00;
   localparam logic [TIM_W-1:0] TIM_RST = 16'h0000;
   localparam logic [DAC_W-1:0] DAC_ZERO = 12'h000;

   typedef enum logic [1:0] {
      CSV_IRQ_SEEK  = 2'd0,
      CSV_IRQ_HOME  = 2'd1,
      CSV_IRQ_ABORT = 2'd2,
      CSV_IRQ_SPARE = 2'd3
   } csv_irq_t;

   // seek command from the supervisory processor
   typedef struct packed {
      logic                 start;
      logic                 inward;
      logic [TRK_W-1:0]     tracks;
   } csv_cmd_t;

   // end-of-seek report
   typedef struct packed {
      logic                 done;
      logic                 ok;
   } csv_stat_t;

   typedef enum logic [0:0] {
      CSV_SPD_LOW  = 1'b0,
      CSV_SPD_HIGH = 1'b1
   } csv_spd_t;
endpackage : csv_pkg

/* File: src/csv_seek_ctrl.sv */
// Purpose: coarse velocity loop of a voice-coil seek controller
// Assumes: crossing pulses and supervisory inputs are asynchronous pins
// Notes:   velocity table is a constant function, no file read
//
// How it works
// - supervisor inputs raise individually maskable events to the seek logic.
// - tracks-to-go counts down by one per crossing during a seek.
// - crossing timer measures time between crossings, readable as output.
// - coarse mode runs until within half a track of destination.
// - velocity table indexed by tracks-to-go, maximum at 255.
// - one table for all seeks; entry chosen by current tracks-to-go.
// - each crossing fetches desired velocity and latches velocity error.
// - between crossings desired current is recomputed and output repeatedly.
// - long seeks switch from high to low speed at a threshold.
// - short seeks stay in low-speed measurement throughout.
// - high-speed table value is a desired time per track.
// - high-speed actual velocity is the timer's time-per-track count.
// - each desired-current step is slew limited by filtering.
// - current sign selects direction, magnitude sets force.
// - direction and first desired velocity come from the destination.
// - every seek ends with a success or failure report.
// - 12-bit current register loads on strobe, servo clear zeroes it.
// - at half a track to go, hand over to the fine loop.
`timescale 1ns/1ps
`default_nettype none
module csv_seek_ctrl #(
   parameter int TIMEOUT = csv_pkg::TIMEOUT_CYC,
   parameter int SWITCH  = csv_pkg::SWITCH_TRK
) (
   // clock and reset
   input  wire logic                          mclk,
   input  wire logic                          rst,
   // supervisory processor
   input  wire csv_pkg::csv_cmd_t             cmd,
   input  wire logic [3:0]                    sup_evt,
   input  wire logic [3:0]                    evt_mask,
   input  wire logic                          servo_clear,
   output csv_pkg::csv_stat_t                 stat,
   output logic [3:0]                         evt_pend,
   // track-crossing pulse pin
   input  wire logic                          xing_pin,
   // desired-current converter
   output logic [csv_pkg::DAC_W-1:0]          dac_data,
   output logic                               dac_load,
   // observed state
   output logic [csv_pkg::TRK_W-1:0]          tracks_to_go,
   output logic [csv_pkg::TIM_W-1:0]          xing_time,
   output logic                               coarse_active,
   output logic                               fine_handover,
   output logic                               high_speed
);
   typedef enum logic [1:0] {S_IDLE, S_COARSE, S_DONE} csv_st_t;
   localparam int TW = csv_pkg::TIM_W;
   localparam int DW = csv_pkg::DAC_W;
   localparam int NW = 20; // signed current working width, holds error << 2

   csv_st_t                  st_r;
   logic [2:0]               xing_sy_r;
   logic [1:0]               start_sy_r;
   logic                     start_d_r;
   logic [1:0]               clr_sy_r;
   logic [csv_pkg::TRK_W:0]  arg_s0_r;
   logic [csv_pkg::TRK_W:0]  arg_s1_r;
   logic [3:0]               evt_s0_r;
   logic [3:0]               evt_s1_r;
   logic [3:0]               evt_d_r;
   logic [3:0]               pend_r;
   logic [csv_pkg::TRK_W-1:0] ttg_r;
   logic [TW-1:0]            tim_r;
   logic [TW-1:0]            cap_r;
   logic                     inward_r;
   logic                     hs_r;
   logic signed [NW-1:0]     err_r;
   logic signed [NW-1:0]     cur_r;
   logic [DW-1:0]            dac_r;
   logic                     load_r;
   logic [15:0]              upd_cnt_r;
   logic [31:0]              to_cnt_r;
   logic                     done_r;
   logic                     ok_r;

   // table: desired time per track, grows as tracks-to-go shrink
   function automatic logic [TW-1:0] vel_tab(input logic [7:0] t);
      logic [TW-1:0] v;
      logic [16:0]   d;
      // 17 bits so the square of 256 at zero tracks does not wrap
      d = 17'(9'd256 - 9'(t));
      v = 16'h0040 + 16'((d * d) >> 4);
      return v;
   endfunction : vel_tab

   // pin synchronisers; logic reads the second stage, the crossing edge detect also the third
   always_ff @(posedge mclk)
   begin
      xing_sy_r  <= {xing_sy_r[1:0], xing_pin};
      start_sy_r <= {start_sy_r[0], cmd.start};
      clr_sy_r   <= {clr_sy_r[0], servo_clear};
      evt_s0_r   <= sup_evt;
      evt_s1_r   <= evt_s0_r;
      arg_s0_r   <= {cmd.inward, cmd.tracks};
      arg_s1_r   <= arg_s0_r;
   end

   wire xing_ev  = xing_sy_r[1] & ~xing_sy_r[2];
   wire start_ev = start_sy_r[1] & ~start_d_r;
   wire clr_s    = clr_sy_r[1];
   wire dir_s    = arg_s1_r[csv_pkg::TRK_W];
   wire [csv_pkg::TRK_W-1:0] trk_s = arg_s1_r[csv_pkg::TRK_W-1:0];
   wire seeking  = (st_r == S_COARSE);
   wire [3:0] evt_rise = evt_s1_r & ~evt_d_r;
   wire [3:0] evt_live = pend_r & ~evt_mask;
   wire abort_ev = evt_live[csv_pkg::CSV_IRQ_ABORT];
   wire [csv_pkg::TRK_W-1:0] ttg_dec = ttg_r - 8'h01;
   wire at_zero  = seeking & xing_ev & (ttg_r == 8'h01);
   wire timeout  = seeking & (to_cnt_r >= 32'(TIMEOUT));
   wire upd_tick = (upd_cnt_r == 16'(csv_pkg::UPD_CYC - 1));

   // desired velocity and measured value in time-per-track form; the
   // low-speed position sensing sits outside, so the timer serves both
   wire [TW-1:0] want_t = vel_tab(ttg_dec);
   wire [TW-1:0] meas_t = tim_r;
   wire signed [NW-1:0] err_nxt =
      NW'($signed({2'b00, meas_t})) - NW'($signed({2'b00, want_t}));
   // slower than wanted (positive error) means push harder
   wire signed [NW-1:0] raw = (err_r <<< csv_pkg::GAIN_SHIFT);
   // clamp before the filter so it never winds up past the converter range
   wire signed [NW-1:0] mag =
      (raw >  NW'(2047)) ?  NW'(2047) :
      (raw < -NW'(2047)) ? -NW'(2047) : raw;
   wire signed [NW-1:0] tgt = inward_r ? mag : -mag;
   // filter the signed output itself so a reversal between seeks slews too
   wire signed [NW-1:0] diff = tgt - cur_r;
   wire signed [NW-1:0] step =
      (diff >  NW'(csv_pkg::SLEW_MAX)) ?  NW'(csv_pkg::SLEW_MAX) :
      (diff < -NW'(csv_pkg::SLEW_MAX)) ? -NW'(csv_pkg::SLEW_MAX) : diff;
   wire signed [NW-1:0] cur_nxt = cur_r + step;
   wire [DW-1:0] dac_nxt = cur_nxt[DW-1:0];

   // supervisory events stick until served; set beats clear
   always_ff @(posedge mclk)
   begin
      if (rst)
         pend_r <= 4'h0;
      else
         pend_r <= evt_rise | (pend_r & ~(evt_live & {4{start_ev}}));
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         evt_d_r   <= 4'h0;
         start_d_r <= 1'b0;
      end
      else
      begin
         evt_d_r   <= evt_s1_r;
         start_d_r <= start_sy_r[1];
      end
   end

   // seek sequencing
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_r     <= S_IDLE;
         ttg_r    <= csv_pkg::TRK_RST;
         inward_r <= 1'b0;
         hs_r     <= 1'b0;
         done_r   <= 1'b0;
         ok_r     <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         unique case (st_r)
            S_IDLE:
               if (start_ev && trk_s != 8'h00)
               begin
                  st_r     <= S_COARSE;
                  ttg_r    <= trk_s;
                  inward_r <= dir_s;
                  hs_r     <= (trk_s > 8'(SWITCH));
               end
               else if (start_ev)
               begin
                  st_r   <= S_DONE;
                  done_r <= 1'b1;
                  ok_r   <= 1'b1;
               end
            S_COARSE:
               if (abort_ev || timeout)
               begin
                  st_r   <= S_DONE;
                  done_r <= 1'b1;
                  ok_r   <= 1'b0;
               end
               else if (at_zero)
               begin
                  st_r   <= S_DONE;
                  ttg_r  <= 8'h00;
                  done_r <= 1'b1;
                  ok_r   <= 1'b1;
               end
               else if (xing_ev)
               begin
                  ttg_r <= ttg_dec;
                  if (ttg_dec <= 8'(SWITCH))
                     hs_r <= 1'b0;
               end
            S_DONE:
               if (start_ev && trk_s != 8'h00)
               begin
                  st_r     <= S_COARSE;
                  ttg_r    <= trk_s;
                  inward_r <= dir_s;
                  hs_r     <= (trk_s > 8'(SWITCH));
               end
               else if (start_ev)
               begin
                  done_r <= 1'b1;
                  ok_r   <= 1'b1;
               end
         endcase
      end
   end

   // crossing timer: capture and restart on every crossing
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         tim_r <= csv_pkg::TIM_RST;
         cap_r <= csv_pkg::TIM_RST;
      end
      else if (xing_ev)
      begin
         cap_r <= tim_r;
         tim_r <= csv_pkg::TIM_RST;
      end
      else if (tim_r != {TW{1'b1}})
         tim_r <= tim_r + 16'h0001;
   end

   // latch velocity error at each crossing
   always_ff @(posedge mclk)
   begin
      if (rst || !seeking)
         err_r <= '0;
      else if (xing_ev)
         err_r <= err_nxt;
   end

   // periodic update of desired current between crossings
   always_ff @(posedge mclk)
   begin
      if (rst)
         upd_cnt_r <= 16'h0000;
      else if (upd_tick || !seeking)
         upd_cnt_r <= 16'h0000;
      else
         upd_cnt_r <= upd_cnt_r + 16'h0001;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         to_cnt_r <= 32'h0000_0000;
      else if (!seeking || xing_ev)
         to_cnt_r <= 32'h0000_0000;
      else
         to_cnt_r <= to_cnt_r + 32'h0000_0001;
   end

   // servo clear wins over any load so no force is applied
   always_ff @(posedge mclk)
   begin
      if (rst || clr_s)
      begin
         cur_r  <= '0;
         dac_r  <= csv_pkg::DAC_ZERO;
         load_r <= 1'b0;
      end
      else if (seeking && upd_tick)
      begin
         cur_r  <= cur_nxt;
         dac_r  <= dac_nxt;
         load_r <= 1'b1;
      end
      else
         load_r <= 1'b0;
   end

   assign stat          = csv_pkg::csv_stat_t'{done: done_r, ok: ok_r};
   assign evt_pend      = pend_r;
   assign dac_data      = dac_r;
   assign dac_load      = load_r;
   assign tracks_to_go  = ttg_r;
   assign xing_time     = cap_r;
   assign coarse_active = seeking;
   assign fine_handover = (st_r == S_DONE) & ok_r;
   assign high_speed    = hs_r;

   property p_dec;
      @(posedge mclk) disable iff (rst)
      (seeking && xing_ev && ttg_r > 8'h01 && !abort_ev && !timeout) |=>
         ttg_r == $past(ttg_r) - 8'h01;
   endproperty
   a_dec: assert property (p_dec) else $error("tracks not decremented");

   property p_cap;
      @(posedge mclk) disable iff (rst)
      xing_ev |=> (cap_r == $past(tim_r)) && (tim_r == 16'h0000);
   endproperty
   a_cap: assert property (p_cap) else $error("timer not captured");

   property p_end;
      @(posedge mclk) disable iff (rst)
      at_zero && !abort_ev && !timeout |=> stat.done && stat.ok && !seeking;
   endproperty
   a_end: assert property (p_end) else $error("seek end missed");

   property p_short;
      @(posedge mclk) disable iff (rst)
      (seeking && ttg_r <= 8'(SWITCH)) |-> !hs_r;
   endproperty
   a_short: assert property (p_short) else $error("high speed too near");

   property p_clr;
      @(posedge mclk) disable iff (rst)
      clr_s |=> dac_data == 12'h000 && !dac_load;
   endproperty
   a_clr: assert property (p_clr) else $error("clear not zeroing");

   property p_slew;
      @(posedge mclk) disable iff (rst)
      (seeking && upd_tick && !clr_s) |=>
         (cur_r - $past(cur_r) <= NW'(csv_pkg::SLEW_MAX)) &&
         ($past(cur_r) - cur_r <= NW'(csv_pkg::SLEW_MAX));
   endproperty
   a_slew: assert property (p_slew) else $error("current step too big");

   sequence s_upd;
      seeking && upd_tick && !clr_s;
   endsequence
   property p_upd;
      @(posedge mclk) disable iff (rst)
      s_upd |=> dac_load;
   endproperty
   a_upd: assert property (p_upd) else $error("no converter load");

   property p_err;
      @(posedge mclk) disable iff (rst)
      (seeking && xing_ev) |=> err_r == $past(err_nxt);
   endproperty
   a_err: assert property (p_err) else $error("error not latched");
endmodule : csv_seek_ctrl
`default_nettype wire

/* File: tb/csv_sup_model.sv */
// Purpose: supervisory processor model that issues seeks
// Assumes: drives its outputs just after the falling mclk edge
// Notes:   latch and status flops are behavioural only
`timescale 1ns/1ps
`default_nettype none
module csv_sup_model (
   // clock and reset
   input  wire logic               mclk,
   input  wire logic               rst,
   // seek side
   output csv_pkg::csv_cmd_t       cmd,
   output logic [3:0]              sup_evt,
   output logic                    servo_clear,
   input  wire csv_pkg::csv_stat_t stat
);
   logic latch_on;
   logic on_track_r;
   logic fault_r;

   // idle levels at time zero, latch still locking the carriage
   initial
   begin
      cmd         = '0;
      sup_evt     = 4'h0;
      servo_clear = 1'b0;
      latch_on    = 1'b0;
   end

   // status flops follow each end-of-seek report
   always_ff @(posedge mclk)
   begin
      if (rst)
         {on_track_r, fault_r} <= 2'b00;
      else if (stat.done)
         {on_track_r, fault_r} <= {stat.ok, !stat.ok};
   end

   // start is held long enough for the two-flop sync to see it
   task automatic seek(input logic inward, input logic [7:0] trk);
   begin
      @(negedge mclk);
      latch_on   = 1'b1;
      cmd.inward = inward;
      cmd.tracks = trk;
      cmd.start  = 1'b1;
      repeat (4) @(negedge mclk);
      cmd.start  = 1'b0;
      // latch never drops here: heads never go back to landing zone
   end
   endtask : seek

   // one event input raised for four cycles, then back to idle
   task automatic evt(input int idx);
   begin
      @(negedge mclk);
      sup_evt[idx] = 1'b1;
      repeat (4) @(negedge mclk);
      sup_evt[idx] = 1'b0;
   end
   endtask : evt

   // servo clear for a few cycles
   task automatic clear();
   begin
      @(negedge mclk);
      servo_clear = 1'b1;
      repeat (4) @(negedge mclk);
      servo_clear = 1'b0;
   end
   endtask : clear
endmodule : csv_sup_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the coarse seek controller
// Assumes: inputs change at falling mclk, outputs sampled there
// Notes:   short timeout and switch-over so the run stays brief
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int TO = 2000;
   localparam int SW = 4;
   logic                           mclk, rst, xing_pin;
   logic [3:0]                     evt_mask, sup_evt, evt_pend;
   logic                           servo_clear, dac_load;
   csv_pkg::csv_cmd_t              cmd;
   csv_pkg::csv_stat_t             stat;
   logic [csv_pkg::DAC_W-1:0]      dac_data, prev_dac;
   logic [csv_pkg::TRK_W-1:0]      ttg;
   logic [csv_pkg::TIM_W-1:0]      xing_time, t1;
   logic                           coarse_active, fine_handover, high_speed;
   logic                           last_ok, hs_seen, s_in;
   int                             fail_count, num_checks, done_cnt, load_cnt;

   csv_seek_ctrl #(.TIMEOUT(TO), .SWITCH(SW)) i_dut (.mclk(mclk), .rst(rst),
      .cmd(cmd), .sup_evt(sup_evt), .evt_mask(evt_mask),
      .servo_clear(servo_clear), .stat(stat), .evt_pend(evt_pend),
      .xing_pin(xing_pin), .dac_data(dac_data), .dac_load(dac_load),
      .tracks_to_go(ttg), .xing_time(xing_time),
      .coarse_active(coarse_active), .fine_handover(fine_handover),
      .high_speed(high_speed));
   csv_sup_model i_sup (.mclk(mclk), .rst(rst), .cmd(cmd),
      .sup_evt(sup_evt), .servo_clear(servo_clear), .stat(stat));

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // event counters kept off the driving edge
   always @(posedge mclk)
   begin
      if (stat.done === 1'b1)
      begin
         done_cnt = done_cnt + 1;
         last_ok  = stat.ok;
      end
      if (high_speed === 1'b1) hs_seen = 1'b1;
      if (dac_load === 1'b1) load_cnt = load_cnt + 1;
   end

   // every load steps at most the slew limit from the held value
   always @(negedge mclk)
   begin
      if (dac_load === 1'b1 && !servo_clear)
         chk(16'(($signed(dac_data - prev_dac) > 64) ||
            ($signed(dac_data - prev_dac) < -64)), 16'h0000);
      prev_dac = dac_data;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
   begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         fail_count = fail_count + 1;
      end
   end
   endtask : chk

   task automatic final_report();
   begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask : final_report

   // bounded wait until the end-of-seek count reaches n
   task automatic wait_done(input int n, input int lim);
   begin
      for (int i = 0; i < lim && done_cnt < n; i++) @(negedge mclk);
      if (done_cnt < n)
      begin
         fail_count = fail_count + 1;
         final_report();
      end
   end
   endtask : wait_done

   // start a seek and wait, bounded, for the coarse loop to engage
   task automatic go(input logic inward, input logic [7:0] trk);
   begin
      i_sup.seek(inward, trk);
      for (int i = 0; i < 10 && coarse_active !== 1'b1; i++) @(negedge mclk);
      if (coarse_active !== 1'b1)
      begin
         fail_count = fail_count + 1;
         final_report();
      end
   end
   endtask : go

   // one crossing pulse, gap counted from its rising edge
   task automatic xing(input int gap);
   begin
      xing_pin = 1'b1;
      repeat (3) @(negedge mclk);
      xing_pin = 1'b0;
      repeat (gap - 3) @(negedge mclk);
   end
   endtask : xing

   // short inward seek: countdown, interval timing, clean finish
   task automatic t_count();
   begin
      hs_seen = 1'b0;
      go(1'b1, 8'h04);
      chk(16'(i_sup.latch_on), 16'h0001);
      chk(16'(ttg), 16'h0004);
      xing(60);
      chk(16'(ttg), 16'h0003);
      s_in = dac_data[11];
      xing(30);
      t1 = xing_time;
      xing(60);
      chk(16'(ttg), 16'h0001);
      chk(t1 - xing_time, 16'h001e);
      xing(30);
      chk(16'(done_cnt), 16'h0001);
      chk(16'(last_ok), 16'h0001);
      chk(16'(fine_handover), 16'h0001);
      chk(16'(coarse_active), 16'h0000);
      chk(16'(hs_seen), 16'h0000);
   end
   endtask : t_count

   // longer outward seek: speed switch-over and steady current updates
   task automatic t_speed();
      int l0;
   begin
      i_sup.clear();
      go(1'b0, 8'h06);
      l0 = load_cnt;
      chk(16'(high_speed), 16'h0001);
      repeat (4) xing(30);
      chk(16'(dac_data[11] ^ s_in), 16'h0001);
      chk(16'(high_speed), 16'h0000);
      chk(16'(load_cnt - l0 >= 6), 16'h0001);
      xing(30);
      xing(30);
      chk(16'(done_cnt), 16'h0002);
   end
   endtask : t_speed

   // abort taken when unmasked, ignored when masked, then timeout
   task automatic t_events();
   begin
      go(1'b1, 8'h0a);
      i_sup.evt(2);
      wait_done(3, 100);
      chk(16'(last_ok), 16'h0000);
      evt_mask = 4'h4;
      go(1'b1, 8'h0a);
      for (int i = 0; i < 4; i++) i_sup.evt(i);
      chk(16'(evt_pend), 16'h000f);
      chk(16'(coarse_active), 16'h0001);
      wait_done(4, TO + 100);
      chk(16'(last_ok), 16'h0000);
      chk(16'({i_sup.on_track_r, i_sup.fault_r}), 16'h0001);
   end
   endtask : t_events

   // servo clear zeroes the current, null seek ends at once
   task automatic t_clear_null();
   begin
      i_sup.clear();
      chk(16'(dac_data), 16'h0000);
      i_sup.seek(1'b1, 8'h00);
      wait_done(5, 20);
      chk(16'(last_ok), 16'h0001);
   end
   endtask : t_clear_null

   initial
   begin
      rst = 1'b1;
      xing_pin = 1'b0;
      evt_mask = 4'h0;
      {fail_count, num_checks, done_cnt, load_cnt} = '0;
      {last_ok, hs_seen, s_in, prev_dac, t1} = '0;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      repeat (3) @(negedge mclk);
      t_count();
      t_speed();
      t_events();
      t_clear_null();
      final_report();
   end
endmodule : tb_top
`default_nettype wire
